// ==== design/ips_pkg.sv ====
// shared constants for the interrupt priority and standby block
package ips_pkg;
  localparam int NUM_SRC = 26; // request sources
  localparam int NUM_VEC = 10; // vector addresses
  localparam int VEC_AW = 17; // vector address width
  localparam int NUM_EXT = 8; // external request pins

  // priority level codes, bigger code outranks smaller
  localparam logic [1:0] LVL_NONE = 2'h0; // nothing in service
  localparam logic [1:0] LVL_LOW = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_TOP = 2'h3; // the highest level

  // vector address of vector n is base plus n times step
  localparam logic [VEC_AW-1:0] VEC_BASE = 17'h00003;
  localparam logic [VEC_AW-1:0] VEC_STEP = 17'h00008;
  localparam logic [VEC_AW-1:0] VEC_LAST = 17'h0004b;

  // source bit positions in the source flag list
  localparam int SRC_EXT0 = 0;
  localparam int SRC_EXT1 = 1;
  localparam int SRC_EXT2 = 2;
  localparam int SRC_TMR0_LO = 3;
  localparam int SRC_EXT4 = 4;
  localparam int SRC_EXT3 = 5;
  localparam int SRC_EXT5 = 6;
  localparam int SRC_BASE_TMR = 7;
  localparam int SRC_TMR0_HI = 8;
  localparam int SRC_EXT6 = 9;
  localparam int SRC_TMR1_LO = 10;
  localparam int SRC_TMR1_HI = 11;
  localparam int SRC_EXT7 = 12;
  localparam int SRC_SYNC0 = 13;
  localparam int SRC_UART_RX = 14;
  localparam int SRC_TMR8_LO = 15;
  localparam int SRC_TMR8_HI = 16;
  localparam int SRC_SYNC1 = 17;
  localparam int SRC_UART_TX = 18;
  localparam int SRC_ADC = 19;
  localparam int SRC_TMR6 = 20;
  localparam int SRC_TMR7 = 21;
  localparam int SRC_PORT0 = 22;
  localparam int SRC_TMR4 = 23;
  localparam int SRC_TMR5 = 24;
  localparam int SRC_PWM = 25; // both pwm channels share this flag

  // sources grouped per vector, vector 0 first
  localparam logic [NUM_SRC-1:0] VEC_SRC [NUM_VEC] = '{
    26'h0000001, 26'h0000002, 26'h000001c, 26'h00000e0, 26'h0000300,
    26'h0001c00, 26'h001e000, 26'h0060000, 26'h0380000, 26'h3c00000};

  // standby states, one-hot
  typedef enum logic [3:0] {
    IPS_RUN = 4'h1,
    IPS_PAUSE = 4'h2,
    IPS_STOP = 4'h4,
    IPS_XSTOP = 4'h8
  } ips_state_t;
endpackage : ips_pkg

// ==== design/ips_top.sv ====
`timescale 1ns/1ps
// Function
// - three levels low, high, highest, two of them legal per vector
// - highest outranks high, high outranks low
// - refuse requests not above level in service
// - simultaneous requests: highest level granted first
// - same level: smallest vector address wins
// - 26 sources combined onto 10 vectors
// - ext zero/one on first vectors, highest or low
// - remaining vectors step eight, high or low
// - readable source flags show branch cause
// - pause stops execution, any interrupt releases
// - full stop halts peripherals and all oscillators
// - full stop released by pin, ext, port0
// - crystal stop keeps base timer and crystal state
// - crystal stop also released by base timer
module ips_top #(
  parameter int NUM_VECTORS = 10 // vector count, fixed by the source grouping
) (
  input wire logic i_clk, // core clock
  input wire logic i_sys_rst, // synchronous system reset
  input wire logic [ips_pkg::NUM_EXT-1:0] i_ext_pin, // external request pins, async
  input wire logic [ips_pkg::NUM_EXT-1:0] i_ext_wake_level, // wake level per pin, 1 = high
  input wire logic i_reset_pin_n, // reset pin, async, low wakes from stop
  input wire logic [ips_pkg::NUM_SRC-1:0] i_periph_event, // peripheral event pulses
  input wire logic [ips_pkg::NUM_SRC-1:0] i_flag_clr, // software clear of source flags
  input wire logic [2*ips_pkg::NUM_VEC-1:0] i_vec_level, // level code per vector
  input wire logic [ips_pkg::NUM_VEC-1:0] i_vec_enable, // per vector enable
  input wire logic i_irq_ack, // core takes the offered vector
  input wire logic i_irq_ret, // core returns from the current handler
  input wire logic i_enter_pause, // core enters pause mode
  input wire logic i_enter_stop, // core enters full-stop mode
  input wire logic i_enter_xstop, // core enters crystal-keeping stop mode
  input wire logic i_xtal_enable, // crystal oscillator setting while running
  output logic o_irq_req, // a vector is offered to the core
  output logic [ips_pkg::VEC_AW-1:0] o_irq_vec_addr, // offered vector address
  output logic [1:0] o_irq_level, // level of the offered vector
  output logic [1:0] o_cur_level, // level now in service
  output logic [ips_pkg::NUM_SRC-1:0] o_source_flag_list, // sticky source flags
  output logic o_cpu_halt, // instruction execution stopped
  output logic o_periph_run, // peripherals clocked
  output logic o_base_timer_run, // base timer clocked
  output logic o_cf_osc_run, // ceramic oscillator on
  output logic o_rc_osc_run, // rc oscillator on
  output logic o_xtal_osc_run // crystal oscillator on
);
  import ips_pkg::*;

  // the grouping table is built for exactly this many vectors
  if (NUM_VECTORS != NUM_VEC) begin : g_bad_vec
    $error("ips_top: NUM_VECTORS must equal the grouping table size");
  end

  // legal level of a vector: first two allow top or low, others high or low
  function automatic logic [1:0] eff_level(input int v, input logic [1:0] cfg);
    logic [1:0] lvl;
    lvl = LVL_LOW;
    if (v < 2) begin
      if (cfg == LVL_TOP) lvl = LVL_TOP;
    end else begin
      if (cfg == LVL_HIGH) lvl = LVL_HIGH;
    end
    return lvl;
  endfunction

  // vector address from vector index
  function automatic logic [VEC_AW-1:0] vec_addr(input logic [3:0] v);
    return VEC_BASE + VEC_STEP * {13'h0000, v};
  endfunction

  // level of the highest bit in service
  function automatic logic [1:0] top_level(input logic [2:0] isr);
    logic [1:0] lvl;
    lvl = LVL_NONE;
    if (isr[2]) lvl = LVL_TOP;
    else if (isr[1]) lvl = LVL_HIGH;
    else if (isr[0]) lvl = LVL_LOW;
    return lvl;
  endfunction

  // ---------------- pin synchronisers ----------------
  logic [NUM_EXT-1:0] ext_s1_q; // first stage, read only by second
  logic [NUM_EXT-1:0] ext_s2_q; // synchronised pin levels
  logic [NUM_EXT-1:0] ext_s3_q; // previous synced level for edges
  logic rst_pin_s1_q; // first stage
  logic rst_pin_s2_q; // synchronised reset pin

  // two flops before anything looks at a pin
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ext_s1_q <= '0;
      ext_s2_q <= '0;
      ext_s3_q <= '0;
      rst_pin_s1_q <= 1'b1;
      rst_pin_s2_q <= 1'b1;
    end else begin
      ext_s1_q <= i_ext_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      rst_pin_s1_q <= i_reset_pin_n;
      rst_pin_s2_q <= rst_pin_s1_q;
    end
  end

  // external pins request on a rising edge; pins 0..7 map onto their flag bits
  logic [NUM_EXT-1:0] ext_rise; // one-cycle rising edge per pin
  logic [NUM_SRC-1:0] src_evt; // all source events this cycle
  always_comb begin
    ext_rise = ext_s2_q & ~ext_s3_q;
    src_evt = i_periph_event;
    src_evt[SRC_EXT0] = i_periph_event[SRC_EXT0] | ext_rise[0];
    src_evt[SRC_EXT1] = i_periph_event[SRC_EXT1] | ext_rise[1];
    src_evt[SRC_EXT2] = i_periph_event[SRC_EXT2] | ext_rise[2];
    src_evt[SRC_EXT3] = i_periph_event[SRC_EXT3] | ext_rise[3];
    src_evt[SRC_EXT4] = i_periph_event[SRC_EXT4] | ext_rise[4];
    src_evt[SRC_EXT5] = i_periph_event[SRC_EXT5] | ext_rise[5];
    src_evt[SRC_EXT6] = i_periph_event[SRC_EXT6] | ext_rise[6];
    src_evt[SRC_EXT7] = i_periph_event[SRC_EXT7] | ext_rise[7];
  end

  // ---------------- flags and pending vectors ----------------
  logic [NUM_SRC-1:0] flags_q; // sticky source flags
  logic [NUM_SRC-1:0] flags_d;
  logic [NUM_VEC-1:0] pend_q; // vector requests waiting for the core
  logic [NUM_VEC-1:0] pend_d;
  logic [2:0] isr_q; // in-service bit per level, low/high/top
  logic [2:0] isr_d;
  logic req_q; // offered to core
  logic req_d;
  logic [3:0] sel_q; // offered vector index
  logic [3:0] sel_d;
  logic [1:0] sel_lvl_q; // offered level
  logic [1:0] sel_lvl_d;
  logic ack_ok; // ack against a live offer

  // set wins over a software clear landing in the same cycle
  always_comb begin
    flags_d = (flags_q & ~i_flag_clr) | src_evt;
  end

  // a vector stays pending until the core takes it, even while blocked
  always_comb begin
    ack_ok = i_irq_ack & req_q;
    for (int v = 0; v < NUM_VEC; v++) begin
      pend_d[v] = (|(src_evt & VEC_SRC[v]))
        | (pend_q[v] & ~(ack_ok && sel_q == 4'(v)));
    end
  end

  // in-service levels: return drops the top one, then an ack adds its level
  always_comb begin
    isr_d = isr_q;
    if (i_irq_ret) begin
      if (isr_d[2]) isr_d[2] = 1'b0;
      else if (isr_d[1]) isr_d[1] = 1'b0;
      else isr_d[0] = 1'b0;
    end
    if (ack_ok) begin
      isr_d[sel_lvl_q - 2'h1] = 1'b1;
    end
  end

  // ---------------- arbiter ----------------
  logic [1:0] cur_lvl; // level now in service
  logic found; // some vector may be granted
  logic [3:0] best_v; // winning vector
  logic [1:0] best_lvl; // its level
  logic [1:0] lvl_v; // loop scratch
  logic any_pend; // an enabled vector waits, used by pause release
  logic st_run_d; // next state is run, offers allowed

  // strict compare keeps the lower vector on ties, scanning from vector 0
  always_comb begin
    cur_lvl = top_level(isr_q);
    found = 1'b0;
    best_v = 4'h0;
    best_lvl = LVL_NONE;
    lvl_v = LVL_NONE;
    for (int v = 0; v < NUM_VEC; v++) begin
      lvl_v = eff_level(v, i_vec_level[2*v +: 2]);
      if (pend_q[v] && i_vec_enable[v] && lvl_v > cur_lvl) begin
        if (!found || lvl_v > best_lvl) begin
          found = 1'b1;
          best_v = 4'(v);
          best_lvl = lvl_v;
        end
      end
    end
    any_pend = |(pend_q & i_vec_enable);
  end

  // offer registered; a taken vector is withdrawn the cycle after its ack
  always_comb begin
    req_d = found & st_run_d & ~ack_ok;
    sel_d = found ? best_v : sel_q;
    sel_lvl_d = found ? best_lvl : sel_lvl_q;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      flags_q <= '0;
      pend_q <= '0;
      isr_q <= 3'h0;
      req_q <= 1'b0;
      sel_q <= 4'h0;
      sel_lvl_q <= LVL_NONE;
    end else begin
      flags_q <= flags_d;
      pend_q <= pend_d;
      isr_q <= isr_d;
      req_q <= req_d;
      sel_q <= sel_d;
      sel_lvl_q <= sel_lvl_d;
    end
  end

  // ---------------- standby control ----------------
  ips_state_t st_q; // standby state
  ips_state_t st_d;
  logic xtal_keep_q; // crystal state caught at crystal-stop entry
  logic xtal_keep_d;
  logic stop_wake; // release shared by both stop modes
  logic [NUM_EXT-1:0] ext_at_lvl; // pins sitting at their wake level

  // only pins 0,1,2,4,5 may release a stop mode
  always_comb begin
    ext_at_lvl = ~(ext_s2_q ^ i_ext_wake_level);
    stop_wake = ~rst_pin_s2_q
      | ext_at_lvl[0] | ext_at_lvl[1] | ext_at_lvl[2] | ext_at_lvl[4] | ext_at_lvl[5]
      | src_evt[SRC_PORT0];
  end

  // mode entry only from run; system reset always lands in run
  always_comb begin
    st_d = st_q;
    xtal_keep_d = xtal_keep_q;
    case (st_q)
      IPS_RUN: begin
        if (i_enter_pause) begin
          st_d = IPS_PAUSE;
        end else if (i_enter_stop) begin
          st_d = IPS_STOP;
        end else if (i_enter_xstop) begin
          st_d = IPS_XSTOP;
          xtal_keep_d = i_xtal_enable;
        end
      end
      IPS_PAUSE: begin
        if (any_pend) st_d = IPS_RUN;
      end
      IPS_STOP: begin
        if (stop_wake) st_d = IPS_RUN;
      end
      IPS_XSTOP: begin
        if (stop_wake || src_evt[SRC_BASE_TMR]) st_d = IPS_RUN;
      end
      default: begin
        st_d = IPS_RUN;
      end
    endcase
    st_run_d = (st_d == IPS_RUN);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_q <= IPS_RUN;
      xtal_keep_q <= 1'b0;
    end else begin
      st_q <= st_d;
      xtal_keep_q <= xtal_keep_d;
    end
  end

  // ---------------- registered outputs ----------------
  logic awake_d; // run or pause: oscillators and peripherals live
  logic xtal_d; // next crystal enable
  always_comb begin
    awake_d = (st_d == IPS_RUN) || (st_d == IPS_PAUSE);
    xtal_d = 1'b0; // full stop halts the crystal too
    if (awake_d) xtal_d = i_xtal_enable;
    else if (st_d == IPS_XSTOP) xtal_d = xtal_keep_d;
  end

  // every port straight from a flop
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_irq_req <= 1'b0;
      o_irq_vec_addr <= VEC_BASE;
      o_irq_level <= LVL_NONE;
      o_cur_level <= LVL_NONE;
      o_source_flag_list <= '0;
      o_cpu_halt <= 1'b0;
      o_periph_run <= 1'b1;
      o_base_timer_run <= 1'b1;
      o_cf_osc_run <= 1'b1;
      o_rc_osc_run <= 1'b1;
      o_xtal_osc_run <= 1'b0;
    end else begin
      o_irq_req <= req_d;
      o_irq_vec_addr <= vec_addr(sel_d);
      o_irq_level <= sel_lvl_d;
      o_cur_level <= top_level(isr_d);
      o_source_flag_list <= flags_d;
      o_cpu_halt <= ~st_run_d;
      o_periph_run <= awake_d;
      o_base_timer_run <= (st_d != IPS_STOP);
      o_cf_osc_run <= awake_d;
      o_rc_osc_run <= awake_d;
      o_xtal_osc_run <= xtal_d;
    end
  end
endmodule // ips_top

// ==== verification/ips_chk.sv ====
`timescale 1ns/1ps
// watches offers, nesting and standby outputs at the top ports
module ips_chk #(
  parameter int NUM_VECTORS = 10 // vector count
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_reset_pin_n,
  input wire logic [ips_pkg::NUM_SRC-1:0] i_periph_event,
  input wire logic i_irq_ack,
  input wire logic i_irq_ret,
  input wire logic i_enter_pause,
  input wire logic i_enter_stop,
  input wire logic i_enter_xstop,
  input wire logic o_irq_req,
  input wire logic [ips_pkg::VEC_AW-1:0] o_irq_vec_addr,
  input wire logic [1:0] o_irq_level,
  input wire logic [1:0] o_cur_level,
  input wire logic [ips_pkg::NUM_SRC-1:0] o_source_flag_list,
  input wire logic o_cpu_halt,
  input wire logic o_periph_run,
  input wire logic o_base_timer_run,
  input wire logic o_cf_osc_run,
  input wire logic o_rc_osc_run,
  input wire logic o_xtal_osc_run
);
  import ips_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // either stop mode, peripherals frozen
  wire logic stopped = o_cpu_halt && !o_periph_run;
  sequence s_take; o_irq_req && i_irq_ack && !i_irq_ret; endsequence
  sequence s_xs; stopped && o_base_timer_run; endsequence
  property p_refuse; o_irq_req |-> o_irq_level > o_cur_level; endproperty
  a_refuse: assert property (p_refuse) else $error("offer not above level");
  property p_lvl; o_irq_req |-> ((o_irq_vec_addr <= 17'h0000b) ?
    (o_irq_level != LVL_HIGH) : (o_irq_level != LVL_TOP)); endproperty
  a_lvl: assert property (p_lvl) else $error("level not allowed here");
  property p_nest; s_take |=> o_cur_level == $past(o_irq_level); endproperty
  a_nest: assert property (p_nest) else $error("level in service wrong");
  property p_pause; i_enter_pause && !o_cpu_halt |=> o_cpu_halt && o_periph_run
    && o_cf_osc_run && o_rc_osc_run; endproperty
  a_pause: assert property (p_pause) else $error("pause entry wrong");
  property p_stop; i_enter_stop && !i_enter_pause && !o_cpu_halt |=> stopped
    && !o_base_timer_run && !o_cf_osc_run && !o_rc_osc_run && !o_xtal_osc_run; endproperty
  a_stop: assert property (p_stop) else $error("full stop entry wrong");
  property p_xstop; i_enter_xstop && !i_enter_pause && !i_enter_stop && !o_cpu_halt
    |=> stopped && o_base_timer_run && !o_cf_osc_run && !o_rc_osc_run; endproperty
  a_xstop: assert property (p_xstop) else $error("crystal stop entry wrong");
  property p_xkeep; s_xs ##1 s_xs |-> $stable(o_xtal_osc_run); endproperty
  a_xkeep: assert property (p_xkeep) else $error("crystal state moved");
  property p_pinwake; stopped && !i_reset_pin_n |-> ##[1:5] !o_cpu_halt; endproperty
  a_pinwake: assert property (p_pinwake) else $error("reset pin no wake");
  property p_basewake; s_xs ##0 i_periph_event[SRC_BASE_TMR] |=> !o_cpu_halt; endproperty
  a_basewake: assert property (p_basewake) else $error("base timer no wake");
  property p_flag; o_periph_run && i_periph_event != '0 |=>
    (o_source_flag_list & $past(i_periph_event)) == $past(i_periph_event); endproperty
  a_flag: assert property (p_flag) else $error("source flag not set");
endmodule // ips_chk

bind ips_top ips_chk #(.NUM_VECTORS(NUM_VECTORS)) u_chk (.*);

// ==== verification/ips_cpu_model.sv ====
`timescale 1ns/1ps
// behavioural core: takes offers, runs nested handlers, returns
module ips_cpu_model (
  input wire logic i_clk,
  input wire logic i_auto, // take offers at all
  input wire logic [7:0] i_wait, // cycles an offer stands before taken
  input wire logic [7:0] i_hold, // handler length in cycles
  input wire logic i_irq_req,
  input wire logic [ips_pkg::VEC_AW-1:0] i_irq_vec_addr,
  input wire logic [1:0] i_irq_level,
  output logic o_irq_ack, // held until the edge that takes it
  output logic o_irq_ret,
  output logic [ips_pkg::VEC_AW-1:0] o_taken_addr, // last vector taken
  output logic [1:0] o_taken_lvl
);
  int depth = 0; // open handlers
  int busy = 0; // cycles in innermost handler
  int seen = 0; // cycles the offer has stood
  // drives just after each edge, never on it
  initial begin
    o_irq_ack = 0;
    o_irq_ret = 0;
    o_taken_addr = '0;
    o_taken_lvl = '0;
    forever begin
      @(posedge i_clk);
      #1;
      o_irq_ret = 0;
      if (depth > 0 && ++busy > i_hold) begin
        o_irq_ret = 1; // innermost handler done
        depth--;
        busy = 0;
      end
      if (o_irq_ack) begin
        o_irq_ack = 0; // taken at the edge just gone
        seen = 0;
      end else if (i_irq_req !== 1'b1) begin
        seen = 0;
      end else if (i_auto && ++seen > i_wait) begin
        o_irq_ack = 1;
        o_taken_addr = i_irq_vec_addr;
        o_taken_lvl = i_irq_level;
        depth++;
        busy = 0;
      end
    end
  end
endmodule // ips_cpu_model

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
// bench for the interrupt priority and standby block
module tb_top;
  import ips_pkg::*;
  logic i_clk = 0;
  logic i_sys_rst = 1;
  logic [NUM_EXT-1:0] i_ext_pin = '0, i_ext_wake_level = '1; // wake on high
  logic i_reset_pin_n = 1, i_enter_pause = 0, i_enter_stop = 0, i_enter_xstop = 0;
  logic i_xtal_enable = 1, i_irq_ack, i_irq_ret, o_irq_req, o_cpu_halt, o_periph_run;
  logic o_base_timer_run, o_cf_osc_run, o_rc_osc_run, o_xtal_osc_run, auto_on = 0;
  logic [NUM_SRC-1:0] i_periph_event = '0, i_flag_clr = '0, o_source_flag_list;
  logic [2*NUM_VEC-1:0] i_vec_level = 20'hd5a6b; // v0 top, v2 v4 v5 high, v1 v9 coerced
  logic [NUM_VEC-1:0] i_vec_enable = '1;
  logic [VEC_AW-1:0] o_irq_vec_addr, taken_addr;
  logic [1:0] o_irq_level, o_cur_level, taken_lvl;
  logic [7:0] ack_wait = 8'h00; // slow core shows offers longer
  int err_count = 0, checked = 0, cycles = 0;
  int wake_pin[5] = '{0, 1, 2, 4, 5};
  ips_top #(.NUM_VECTORS(10)) u_dut (.*);
  ips_cpu_model u_cpu (.i_clk(i_clk), .i_auto(auto_on), .i_wait(ack_wait),
    .i_hold(8'h06), .i_irq_req(o_irq_req), .i_irq_vec_addr(o_irq_vec_addr),
    .i_irq_level(o_irq_level), .o_irq_ack(i_irq_ack), .o_irq_ret(i_irq_ret),
    .o_taken_addr(taken_addr), .o_taken_lvl(taken_lvl));
  initial forever #5 i_clk = ~i_clk;
  // hang guard, the run needs about 340 cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic ev(input logic [NUM_SRC-1:0] m);
    i_periph_event = m;
    tick(1);
    i_periph_event = '0;
  endtask
  // waits for the core to take a vector, then compares it
  task automatic take(input logic [VEC_AW-1:0] a, input logic [1:0] l);
    int n = 0;
    do @(posedge i_clk); while (i_irq_ack !== 1'b1 && ++n < 60);
    #1;
    chk("vector", taken_addr, a);
    chk("level", taken_lvl, l);
  endtask
  task automatic prio_nest();
    ack_wait = 8'h03;
    auto_on = 1;
    ev((26'h1 << SRC_TMR0_LO) | (26'h1 << SRC_TMR1_LO) | (26'h1 << SRC_ADC));
    take(17'h00013, LVL_HIGH);
    ev(26'h1 << SRC_TMR0_HI);
    tick(2);
    chk("refused", o_irq_req, 0);
    take(17'h00023, LVL_HIGH);
    take(17'h0002b, LVL_HIGH);
    take(17'h00043, LVL_LOW);
    ev(26'h1 << SRC_EXT0);
    take(17'h00003, LVL_TOP);
    ev((26'h1 << SRC_EXT1) | (26'h1 << SRC_PORT0));
    take(17'h0000b, LVL_LOW);
    take(17'h0004b, LVL_LOW);
    chk("flags", o_source_flag_list, 26'h048050b);
    i_flag_clr = '1;
    tick(1);
    i_flag_clr = '0;
    chk("cleared", o_source_flag_list, 0);
  endtask
  task automatic pause_wake();
    ack_wait = 8'h00;
    tick(20);
    i_enter_pause = 1;
    tick(1);
    i_enter_pause = 0;
    tick(1);
    chk("paused", {o_cpu_halt, o_periph_run, o_cf_osc_run, o_rc_osc_run}, 4'hf);
    ev(26'h1 << SRC_UART_RX);
    tick(1);
    chk("resumed", o_cpu_halt, 0);
    take(17'h00033, LVL_LOW);
  endtask
  // kind 0 pin, 1 reset pin, 2 peripheral event
  task automatic standby(input logic xs, input int kind, input int idx, input logic wake);
    int n;
    i_xtal_enable = 1;
    tick(2);
    i_enter_stop = !xs;
    i_enter_xstop = xs;
    tick(1);
    i_enter_stop = 0;
    i_enter_xstop = 0;
    i_xtal_enable = 0; // crystal must not follow this while held
    tick(1);
    chk("halted", {o_cpu_halt, o_periph_run, o_cf_osc_run, o_rc_osc_run}, 4'h8);
    chk("kept", {o_base_timer_run, o_xtal_osc_run}, {xs, xs});
    if (kind == 0) i_ext_pin[idx] = 1;
    else if (kind == 1) i_reset_pin_n = 0;
    else ev(26'h1 << idx);
    for (n = 0; n < 8 && o_cpu_halt === 1'b1; n++) tick(1);
    chk("woken", !o_cpu_halt, wake);
    i_ext_pin = '0;
    i_reset_pin_n = 0;
    for (n = 0; n < 8 && o_cpu_halt === 1'b1; n++) tick(1);
    i_reset_pin_n = 1;
    chk("running", o_periph_run, 1);
    tick(12);
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    #1;
    i_sys_rst = 0;
    tick(3);
    prio_nest();
    pause_wake();
    foreach (wake_pin[i]) standby(0, 0, wake_pin[i], 1);
    standby(0, 0, 3, 0);
    standby(0, 1, 0, 1);
    standby(0, 2, SRC_PORT0, 1);
    standby(0, 2, SRC_BASE_TMR, 0);
    standby(1, 2, SRC_BASE_TMR, 1);
    standby(1, 0, 4, 1);
    stop_test();
  end
endmodule // tb_top
